//--- adc_output_stage_control.sv
`timescale 1ns/1ps
`include "adc_out_params.svh"
// Operation
// - output enable high floats data and flag
// - output enable low drives code and flag
// - standby high freezes outputs at last state
// - standby low keeps outputs updating
// - in-range code is straight 10-bit binary
// - in-range samples drive flag high
// - underflow gives zero code, flag low
// - overflow gives full code, flag low
// - standby entry completes within 200 ns
// - valid results resume within 500 ns
// - output enable input is active low
// - bit 9 is msb, bit 0 lsb
module adc_output_stage_control
	import adc_out_pkg::*;
#(
	parameter int DEPTH = `FIFO_DEPTH
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// sampling enable, one per conversion
	input wire logic sample_en,
	// quantiser result and range class
	input wire logic [`CODE_W-1:0] raw_code,
	input wire range_t raw_range,
	// control pins
	input wire logic out_enable_n,
	input wire logic sleep_hold_pin,
	// data pins as output and enable (enable low drives)
	output logic [`CODE_W-1:0] sample_code_out,
	output logic [`CODE_W-1:0] sample_code_oe_n,
	output logic in_range_flag,
	output logic in_range_oe_n,
	// status
	output logic results_valid,
	output logic sleep_hold
);
	localparam int W = `CODE_W + 1;
	localparam int ENTRY_CYC = `SLEEP_ENTRY_CYC;
	localparam int EXIT_CYC = `SLEEP_EXIT_CYC;
	// cycles the wake check allows after its first nine
	localparam int WAKE_TAIL = EXIT_CYC - 8;
	// refuse standby timings that the wake counter and checks cannot serve
	if (ENTRY_CYC < 1 || EXIT_CYC < 9 || EXIT_CYC > 256)
	begin : g_bad_timing
		$error("standby timing outside what the wake counter serves");
	end
	// state of the block outside the fifo
	typedef struct packed {
		power_t pwr;
		logic [7:0] wake_cnt;
		logic [`CODE_W-1:0] code;
		logic flag;
	} top_state_t;
	top_state_t cur;
	top_state_t next_cur;
	logic [`CODE_W-1:0] conv_code;
	logic conv_flag;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [W-1:0] fifo_out_data;
	logic take;
	// saturate and flag by range class
	always_comb
	begin
		conv_code = raw_code;
		conv_flag = 1'b1;
		case (raw_range)
			RANGE_UNDER:
			begin
				conv_code = `CODE_ZERO;
				conv_flag = 1'b0;
			end
			RANGE_OVER:
			begin
				conv_code = `CODE_FULL;
				conv_flag = 1'b0;
			end
			default:
			begin
				conv_code = raw_code;
				conv_flag = 1'b1;
			end
		endcase
	end
	// fifo keeps result order fixed; stalls while frozen
	sample_fifo #(.WIDTH(W), .DEPTH(DEPTH)) u_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(sample_en && cur.pwr == ST_RUN),
		.in_ready(fifo_in_ready),
		.in_data({conv_flag, conv_code}),
		.out_valid(fifo_out_valid),
		.out_ready(take),
		.out_data(fifo_out_data)
	);
	// drain one word per sample enable while running
	assign take = sample_en && cur.pwr == ST_RUN;
	// power sequencing and output word update
	always_comb
	begin
		next_cur = cur;
		case (cur.pwr)
			ST_RUN:
			begin
				// a word popped on the entry edge must land, or it is lost
				if (take && fifo_out_valid)
				begin
					next_cur.code = fifo_out_data[`CODE_W-1:0];
					next_cur.flag = fifo_out_data[`CODE_W];
				end
				if (sleep_hold_pin)
					next_cur.pwr = ST_SLEEP; // one cycle
			end
			ST_SLEEP:
			begin
				// hold last word; stale fifo words are stale data
				if (!sleep_hold_pin)
				begin
					next_cur.pwr = ST_WAKE;
					next_cur.wake_cnt = 8'h00;
				end
			end
			ST_WAKE:
			begin
				if (sleep_hold_pin)
					next_cur.pwr = ST_SLEEP;
				// pin is seen one edge late: run resumes EXIT_CYC after it falls
				else if (cur.wake_cnt == 8'(EXIT_CYC - 2))
					next_cur.pwr = ST_RUN;
				else
					next_cur.wake_cnt = cur.wake_cnt + 8'h01;
			end
			default:
				next_cur.pwr = ST_RUN;
		endcase
	end
	// state register
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			cur.pwr <= ST_RUN;
			cur.wake_cnt <= 8'h00;
			cur.code <= `CODE_ZERO;
			cur.flag <= 1'b0;
		end
		else
			cur <= next_cur;
	end
	// data from flops; enable only switches drivers
	assign sample_code_out = cur.code;
	assign in_range_flag = cur.flag;
	assign sample_code_oe_n = {`CODE_W{out_enable_n}};
	assign in_range_oe_n = out_enable_n;
	assign results_valid = (cur.pwr == ST_RUN);
	assign sleep_hold = (cur.pwr != ST_RUN);
	// output enable follows the pin directly
	property p_oe_follow;
		@(posedge core_clk) disable iff (rst)
		in_range_oe_n == out_enable_n && sample_code_oe_n[9] == out_enable_n;
	endproperty
	a_oe_follow: assert property (p_oe_follow)
		else $error("output enable not following pin");
	// frozen word stays while asleep
	property p_freeze;
		@(posedge core_clk) disable iff (rst)
		(cur.pwr == ST_SLEEP) ##1 (cur.pwr == ST_SLEEP)
			|-> $stable(sample_code_out) && $stable(in_range_flag);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("outputs changed in standby");
	// standby entered one cycle after pin rises
	property p_entry;
		@(posedge core_clk) disable iff (rst)
		(cur.pwr == ST_RUN && sleep_hold_pin) |=> cur.pwr == ST_SLEEP;
	endproperty
	a_entry: assert property (p_entry)
		else $error("standby entry too slow");
	// wake sequence lasts the start-up count
	sequence s_wake_start;
		cur.pwr == ST_SLEEP && !sleep_hold_pin;
	endsequence
	property p_wake;
		@(posedge core_clk) disable iff (rst)
		s_wake_start ##1 (!sleep_hold_pin)[*8]
			|-> ##[0:WAKE_TAIL] (results_valid || sleep_hold_pin);
	endproperty
	a_wake: assert property (p_wake)
		else $error("start-up time exceeded");
	// underflow word carries zero code and low flag
	property p_under;
		@(posedge core_clk) disable iff (rst)
		(take && fifo_out_valid
			&& fifo_out_data[`CODE_W] == 1'b0
			&& fifo_out_data[`CODE_W-1:0] == `CODE_ZERO)
			|=> !in_range_flag && sample_code_out == `CODE_ZERO;
	endproperty
	a_under: assert property (p_under)
		else $error("underflow word wrong");
	// flag low only with a saturated code
	property p_sat;
		@(posedge core_clk) disable iff (rst)
		!in_range_flag |-> (sample_code_out == `CODE_ZERO
			|| sample_code_out == `CODE_FULL);
	endproperty
	a_sat: assert property (p_sat)
		else $error("out-of-range flag with unsaturated code");
	// overflow word carries full code and low flag
	property p_over;
		@(posedge core_clk) disable iff (rst)
		(take && fifo_out_valid
			&& fifo_out_data[`CODE_W] == 1'b0
			&& fifo_out_data[`CODE_W-1:0] == `CODE_FULL)
			|=> !in_range_flag && sample_code_out == `CODE_FULL;
	endproperty
	a_over: assert property (p_over)
		else $error("overflow word wrong");
	// every popped word reaches the pins next cycle, in order
	property p_land;
		@(posedge core_clk) disable iff (rst)
		(take && fifo_out_valid)
			|=> {in_range_flag, sample_code_out} == $past(fifo_out_data);
	endproperty
	a_land: assert property (p_land)
		else $error("popped word did not reach the outputs");
endmodule : adc_output_stage_control

//--- adc_out_params.svh
`ifndef ADC_OUT_PARAMS_SVH
`define ADC_OUT_PARAMS_SVH
// core clock period in picoseconds (40 MHz)
`define CLK_PERIOD_PS 25000
// standby entry time, longest, in ns
`define SLEEP_ENTRY_NS 200
// standby exit start-up time, longest, in ns
`define SLEEP_EXIT_NS 500
// longest times round down to whole cycles
`define SLEEP_ENTRY_CYC ((`SLEEP_ENTRY_NS * 1000) / `CLK_PERIOD_PS)
`define SLEEP_EXIT_CYC ((`SLEEP_EXIT_NS * 1000) / `CLK_PERIOD_PS)
// code width and saturation codes
`define CODE_W 10
`define CODE_ZERO 10'h000
`define CODE_FULL 10'h3ff
// fifo depth in the sample path
`define FIFO_DEPTH 8
`endif

//--- adc_out_pkg.sv
`include "adc_out_params.svh"
package adc_out_pkg;
	// sample range class from the quantiser
	typedef enum logic [1:0] {
		RANGE_IN = 2'h0,
		RANGE_UNDER = 2'h1,
		RANGE_OVER = 2'h2
	} range_t;
	// power state, one-hot
	typedef enum logic [2:0] {
		ST_RUN = 3'h1,
		ST_SLEEP = 3'h2,
		ST_WAKE = 3'h4
	} power_t;
endpackage : adc_out_pkg

//--- sample_fifo.sv
`timescale 1ns/1ps
// small flop fifo with valid/ready on both sides
module sample_fifo
#(
	parameter int WIDTH = 11,
	parameter int DEPTH = 8
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	// pointers wrap by overflow, so only powers of two are served
	if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH)
	begin : g_bad_depth
		$error("depth must be a power of two, at least 2");
	end
	// all state in one struct
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] count;
	} fifo_state_t;
	fifo_state_t cur;
	fifo_state_t next_cur;
	logic push;
	logic pop;
	assign in_ready = (cur.count != (AW+1)'(DEPTH));
	assign out_valid = (cur.count != '0);
	assign out_data = cur.mem[cur.rd];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// pointer and count update
	always_comb
	begin
		next_cur = cur;
		if (push)
		begin
			next_cur.mem[cur.wr] = in_data;
			next_cur.wr = cur.wr + 1'b1;
		end
		if (pop)
			next_cur.rd = cur.rd + 1'b1;
		if (push && !pop)
			next_cur.count = cur.count + 1'b1;
		else if (pop && !push)
			next_cur.count = cur.count - 1'b1;
	end
	// register, pointers cleared on reset
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			cur.wr <= '0;
			cur.rd <= '0;
			cur.count <= '0;
			cur.mem <= cur.mem;
		end
		else
			cur <= next_cur;
	end
endmodule : sample_fifo

//--- capture_model.sv
`timescale 1ns/1ps
// downstream logic that latches the parallel word
module capture_model
(
	// clock
	input wire logic core_clk,
	// resolved pins
	input wire logic [9:0] code_pin,
	input wire logic flag_pin,
	// captured word, flag on top
	output logic [10:0] cap_word
);
	// one capture a clock, a full period after launch
	always_ff @(posedge core_clk)
	begin
		cap_word <= {flag_pin, code_pin};
	end
endmodule : capture_model

//--- testbench.sv
`timescale 1ns/1ps
// self-checking bench for the output stage
module testbench
	import adc_out_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic sample_en = 1'b0;
	logic [9:0] raw_code = 10'h000;
	range_t raw_range = RANGE_IN;
	logic out_enable_n = 1'b0;
	logic sleep_hold_pin = 1'b0;
	logic [9:0] sample_code_out, sample_code_oe_n;
	logic in_range_flag, in_range_oe_n, results_valid, sleep_hold;
	wire [9:0] code_pin;
	wire flag_pin;
	logic [10:0] cap_word;
	int n_fail = 0;
	int checked = 0;
	// 25 ns period
	always #12.5 core_clk = ~core_clk;
	adc_output_stage_control dut (.core_clk, .rst, .sample_en, .raw_code,
		.raw_range, .out_enable_n, .sleep_hold_pin, .sample_code_out,
		.sample_code_oe_n, .in_range_flag, .in_range_oe_n, .results_valid,
		.sleep_hold);
	capture_model cap (.core_clk, .code_pin, .flag_pin, .cap_word);
	// each pin floats while its own enable is high
	for (genvar i = 0; i < 10; i++)
	begin : g_pin
		assign code_pin[i] = sample_code_oe_n[i] ? 1'bz : sample_code_out[i];
	end
	assign flag_pin = in_range_oe_n ? 1'bz : in_range_flag;
	task automatic chk(input string what, input logic [10:0] e, g);
		checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, e, g);
		end
	endtask : chk
	// one strobe, then a quiet cycle: sampling rate stays at half
	task automatic strobe(input logic [9:0] c, input range_t r);
		raw_code <= c;
		raw_range <= r;
		sample_en <= 1'b1;
		@(posedge core_clk);
		sample_en <= 1'b0;
		@(posedge core_clk);
	endtask : strobe
	// pins now, then what the far side latched one edge later
	task automatic look(input string what, input logic [10:0] e);
		#1;
		chk(what, e, {flag_pin, code_pin});
		@(posedge core_clk);
		#1;
		chk({what, " capture"}, e, cap_word);
		@(posedge core_clk);
	endtask : look
	// saturation overrides the code on out-of-range samples
	function automatic logic [10:0] want(input logic [9:0] c, range_t r);
		case (r)
			RANGE_UNDER: return 11'h000;
			RANGE_OVER: return 11'h3ff;
			default: return {1'b1, c};
		endcase
	endfunction : want
	task automatic coding_test;
		logic [9:0] c [5] = '{10'h155, 10'h000, 10'h3ff, 10'h201, 10'h012};
		range_t r [5] = '{RANGE_UNDER, RANGE_IN, RANGE_IN, RANGE_IN,
			RANGE_OVER};
		chk("reset word", 11'h000, {flag_pin, code_pin});
		for (int i = 0; i < 5; i++)
		begin
			strobe(c[i], r[i]);
			if (i > 0)
				look("word", want(c[i-1], r[i-1]));
		end
		strobe(10'h0aa, RANGE_IN);
		look("last word", 11'h3ff);
	endtask : coding_test
	task automatic oe_test;
		out_enable_n <= 1'b1;
		strobe(10'h2c3, RANGE_IN);
		#1;
		chk("floating pins", 11'hzzz, {flag_pin, code_pin});
		@(posedge core_clk);
		out_enable_n <= 1'b0;
		strobe(10'h0f0, RANGE_OVER);
		look("after float", 11'h6c3);
	endtask : oe_test
	// bounded wait for a status level, counting edges
	task automatic wait_lvl(input bit hold, input int lim, output int n);
		n = 0;
		while ((hold ? sleep_hold !== 1'b1 : results_valid !== 1'b1)
			&& n <= lim)
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk("wait ok", 11'h001, {10'h000, n <= lim});
		if (n > lim)
			end_of_test();
		@(posedge core_clk);
	endtask : wait_lvl
	task automatic sleep_test;
		int n;
		sleep_hold_pin <= 1'b1;
		wait_lvl(1'b1, 8, n);
		chk("valid asleep", 11'h000, {10'h000, results_valid});
		strobe(10'h111, RANGE_IN);
		look("frozen", 11'h6c3);
		sleep_hold_pin <= 1'b0;
		wait_lvl(1'b0, 20, n);
		strobe(10'h3a5, RANGE_IN);
		look("woken", 11'h3ff);
	endtask : sleep_test
	// a strobe on the standby entry edge still lands, and the sample it
	// pushes waits in the fifo until after wake-up
	task automatic entry_test;
		int n;
		raw_code <= 10'h0c3;
		raw_range <= RANGE_IN;
		sample_en <= 1'b1;
		sleep_hold_pin <= 1'b1;
		@(posedge core_clk);
		sample_en <= 1'b0;
		sleep_hold_pin <= 1'b0;
		look("entry word", 11'h7a5);
		wait_lvl(1'b0, 20, n);
		strobe(10'h000, RANGE_IN);
		look("kept word", 11'h4c3);
	endtask : entry_test
	task automatic end_of_test;
		if (n_fail == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test
	// reset for two edges, then the scenarios
	initial
	begin
		@(posedge core_clk);
		@(posedge core_clk);
		rst <= 1'b0;
		coding_test();
		oe_test();
		sleep_test();
		entry_test();
		end_of_test();
	end
endmodule : testbench
